// ---- ivr_consts.vh ----
// constants for the interrupt vector resolver
`ifndef IVR_CONSTS_VH
`define IVR_CONSTS_VH
// ==========================================
// newer device: 2-byte vector table
`define IVR_VEC_ENTRY_BYTES 2
`define IVR_VEC_RESET 16'h0000
`define IVR_VEC_WDT 16'h0004
`define IVR_VEC_LVI 16'h0006
`define IVR_VEC_PIN0 16'h0008
`define IVR_VEC_SER2_TX 16'h0014
`define IVR_VEC_SER2_RX 16'h0016
`define IVR_VEC_SER2_ERR 16'h0018
`define IVR_VEC_SER0_TX 16'h001E
`define IVR_VEC_SER0_RX 16'h0020
`define IVR_VEC_SER0_ERR 16'h0022
`define IVR_REGION_TOP 20'h0FFFF
`define IVR_PRIO_LOWEST 6'h2C
// source index = default priority, 0..13 modelled
`define IVR_NSRC 14
// ==========================================
// older device: relocatable 4-byte table
`define IVR_REL_ENTRY_BYTES 4
`define IVR_REL_TABLE_BYTES 256
`define IVR_SWN_TIMER_A 6'h16
`define IVR_SWN_TIMER_B 6'h18
`define IVR_SWN_EXT1 6'h19
`define IVR_SWN_EXT3 6'h1A
`define IVR_SWN_SSU_IIC 6'h0F
`define IVR_SWN_VMON1 6'h32
`define IVR_SWN_VMON2 6'h33
`define IVR_SWN_NOMASK_LO 6'h20
`define IVR_SWN_NOMASK_HI 6'h29
`endif

// ---- ivr_prio_enc.v ----
// fixed-priority encoder: lowest index wins
`timescale 1ns/1ps
module ivr_prio_enc #(
  parameter N = 14,
  parameter W = 6
) (
  // request vector
  input wire [N-1:0] i_req,
  // result
  output reg o_any,
  output reg [W-1:0] o_idx
);
  integer k;
  // ==========================================
  // search from the top down so index 0 is taken last and wins
  always @* begin
    o_any = 1'b0;
    o_idx = {W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = k[W-1:0];
      end
    end
  end
endmodule // ivr_prio_enc

// ---- ivr_resolver.v ----
// interrupt vector resolver for the newer and older table formats
// Function
// - newer device vector entries are two bytes
// - branch target lies within lowest 64 KB
// - priority 0 highest, 44 lowest, smallest served
// - acknowledge presents the source vector location
// - watchdog interval: priority 0, vector 0004H
// - pin edges 0-5: priorities 2-7, 0008H-0012H
// - serial2 transmit group: priority 8, 0014H
// - serial2 receive group: priority 9, 0016H
// - serial2 error, timer11 upper: priority 10, 0018H
// - serial0 tx 11 at 001EH, rx 12 0020H
// - serial0 error, timer1 upper: priority 13, 0022H
// - older entry offset is four times number
// - timer B 24, ext1 25, ext3 26
// - numbers 32 to 41 ignore enable flag
// - shared serial entry attributed by select bit
// - voltage monitors use 50/51 only maskable
// - relocatable table spans 256 bytes from base
// - all reset sources share vector 0000H
`timescale 1ns/1ps
`include "ivr_consts.vh"
module ivr_resolver #(
  parameter AW = 20
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // newer device request lines
  input wire i_watchdog_interval_irq,
  input wire i_voltage_detect_irq,
  input wire [5:0] i_pin_edge_irq,
  input wire i_serial2_tx_end_irq,
  input wire i_serial2_clocked_tx_irq,
  input wire i_serial2_simple_i2c_irq,
  input wire i_serial2_rx_end_irq,
  input wire i_serial2_rx_error_irq,
  input wire i_timer11_upper_half_irq,
  input wire i_serial0_tx_end_irq,
  input wire i_serial0_rx_end_irq,
  input wire i_serial0_rx_error_irq,
  input wire i_timer1_upper_half_irq,
  input wire i_reset_source,
  // newer device cpu handshake
  input wire i_cpu_ack,
  input wire [15:0] i_vec_entry_data,
  // older device request side
  input wire i_rel_req,
  input wire [5:0] i_rel_swnum,
  input wire i_global_irq_enable,
  input wire i_serial_unit_select_bit,
  input wire i_vmon_maskable,
  input wire [AW-1:0] i_table_base_register,
  input wire i_rel_ack,
  // newer device outputs
  output wire o_irq_pending,
  output reg [5:0] o_pend_prio,
  output reg [15:0] o_vec_loc,
  output reg o_vec_valid,
  output reg [19:0] o_branch_target,
  output reg o_reset_vec,
  // older device outputs
  output wire o_rel_pending,
  output reg [AW-1:0] o_rel_entry_addr,
  output reg o_rel_valid,
  output reg o_rel_is_iic,
  output reg o_rel_refused
);
  // ==========================================
  // source vector by default priority
  localparam NS = `IVR_NSRC;

  // vector location of each modelled priority level, two bytes apart except the six-byte step from 0018H to 001EH
  function [15:0] prio_to_vec;
    input [5:0] p;
    begin
      case (p)
        6'h00: prio_to_vec = `IVR_VEC_WDT;
        6'h01: prio_to_vec = `IVR_VEC_LVI;
        6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07:
          prio_to_vec = `IVR_VEC_PIN0 + {9'h000, p - 6'h02, 1'b0};
        6'h08: prio_to_vec = `IVR_VEC_SER2_TX;
        6'h09: prio_to_vec = `IVR_VEC_SER2_RX;
        6'h0A: prio_to_vec = `IVR_VEC_SER2_ERR;
        6'h0B: prio_to_vec = `IVR_VEC_SER0_TX;
        6'h0C: prio_to_vec = `IVR_VEC_SER0_RX;
        6'h0D: prio_to_vec = `IVR_VEC_SER0_ERR;
        default: prio_to_vec = `IVR_VEC_RESET;
      endcase
    end
  endfunction

  // numbers 32..41 ignore the global enable
  function is_nomask;
    input [5:0] n;
    begin
      is_nomask = (n >= `IVR_SWN_NOMASK_LO) && (n <= `IVR_SWN_NOMASK_HI);
    end
  endfunction

  // ==========================================
  // request vector, index = default priority
  // shared sources merge into one line; software reads the flags to tell them apart
  wire [NS-1:0] req;
  assign req[0] = i_watchdog_interval_irq;
  assign req[1] = i_voltage_detect_irq;
  assign req[7:2] = i_pin_edge_irq;
  assign req[8] = i_serial2_tx_end_irq | i_serial2_clocked_tx_irq |
    i_serial2_simple_i2c_irq;
  assign req[9] = i_serial2_rx_end_irq;
  assign req[10] = i_serial2_rx_error_irq | i_timer11_upper_half_irq;
  assign req[11] = i_serial0_tx_end_irq;
  assign req[12] = i_serial0_rx_end_irq;
  assign req[13] = i_serial0_rx_error_irq | i_timer1_upper_half_irq;

  wire win_any;
  wire [5:0] win_idx;
  ivr_prio_enc #(
    .N(NS),
    .W(6)
  ) u_enc (
    .i_req(req),
    .o_any(win_any),
    .o_idx(win_idx)
  );

  assign o_irq_pending = win_any | i_reset_source;

  // ==========================================
  // newer device: latch vector on acknowledge
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pend_prio <= `IVR_PRIO_LOWEST;
      o_vec_loc <= 16'h0000;
      o_vec_valid <= 1'b0;
      o_reset_vec <= 1'b0;
    end else begin
      o_vec_valid <= 1'b0;
      o_pend_prio <= win_any ? win_idx : `IVR_PRIO_LOWEST;
      if (i_cpu_ack && o_irq_pending) begin
        o_vec_valid <= 1'b1;
        // a reset source outranks every maskable request
        if (i_reset_source) begin
          o_vec_loc <= `IVR_VEC_RESET;
          o_reset_vec <= 1'b1;
        end else begin
          o_vec_loc <= prio_to_vec(win_idx);
          o_reset_vec <= 1'b0;
        end
      end
    end
  end

  // branch target: stored 16-bit entry placed in the lowest 64 KB
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_branch_target <= 20'h00000;
    end else if (o_vec_valid) begin
      o_branch_target <= {4'h0, i_vec_entry_data} & `IVR_REGION_TOP;
    end
  end

  // ==========================================
  // older device: relocatable table lookup
  // reserved numbers still map; software must not raise them
  wire rel_vmon = (i_rel_swnum == `IVR_SWN_VMON1) || (i_rel_swnum == `IVR_SWN_VMON2);
  wire rel_take = i_rel_req && (i_global_irq_enable || is_nomask(i_rel_swnum)) &&
    !(rel_vmon && !i_vmon_maskable);
  wire [7:0] rel_off = {i_rel_swnum, 2'b00};
  assign o_rel_pending = rel_take;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rel_entry_addr <= {AW{1'b0}};
      o_rel_valid <= 1'b0;
      o_rel_is_iic <= 1'b0;
      o_rel_refused <= 1'b0;
    end else begin
      o_rel_valid <= 1'b0;
      o_rel_refused <= 1'b0;
      if (i_rel_ack && i_rel_req) begin
        if (rel_take) begin
          o_rel_valid <= 1'b1;
          // the 8-bit offset keeps every entry inside the 256-byte table
          o_rel_entry_addr <= i_table_base_register + {{(AW-8){1'b0}}, rel_off};
          o_rel_is_iic <= (i_rel_swnum == `IVR_SWN_SSU_IIC) &&
            i_serial_unit_select_bit;
        end else begin
          o_rel_refused <= 1'b1;
        end
      end
    end
  end
endmodule // ivr_resolver

// ---- ivr_resolver_sva.sv ----
// checker for the interrupt vector resolver
`timescale 1ns/1ps
module ivr_resolver_sva #(parameter AW = 20) (
  input wire i_ref_clk, i_resetn, i_watchdog_interval_irq, i_reset_source, i_cpu_ack,
  input wire [15:0] i_vec_entry_data,
  input wire i_rel_req, i_global_irq_enable, i_serial_unit_select_bit, i_vmon_maskable,
  input wire [5:0] i_rel_swnum,
  input wire [AW-1:0] i_table_base_register,
  input wire i_rel_ack, o_irq_pending, o_vec_valid, o_reset_vec,
  input wire [5:0] o_pend_prio,
  input wire [15:0] o_vec_loc,
  input wire [19:0] o_branch_target,
  input wire [AW-1:0] o_rel_entry_addr,
  input wire o_rel_valid, o_rel_is_iic, o_rel_refused
);
  // =====
  // properties
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire tk = i_rel_ack && i_rel_req;
  wire nm = i_rel_swnum >= 6'h20 && i_rel_swnum <= 6'h29;
  ack_vec_a: assert property (i_cpu_ack && o_irq_pending |=> o_vec_valid)
    else $error("ack gave no vector");
  no_ack_a: assert property (!(i_cpu_ack && o_irq_pending) |=> !o_vec_valid)
    else $error("vector without ack");
  wdt_loc_a: assert property (o_vec_valid && $past(i_watchdog_interval_irq && !i_reset_source)
    |-> o_vec_loc == 16'h0004) else $error("watchdog vector wrong");
  rst_loc_a: assert property (o_vec_valid && $past(i_reset_source)
    |-> o_vec_loc == 16'h0000 && o_reset_vec) else $error("reset vector wrong");
  vec_even_a: assert property (o_vec_valid |-> !o_vec_loc[0])
    else $error("odd vector location");
  tgt_load_a: assert property (o_vec_valid |=> o_branch_target == {4'h0, $past(i_vec_entry_data)})
    else $error("branch target wrong");
  idle_prio_a: assert property (!o_irq_pending ##1 !o_irq_pending |-> o_pend_prio == 6'h2C)
    else $error("idle priority wrong");
  rel_addr_a: assert property (o_rel_valid |-> o_rel_entry_addr ==
    $past(i_table_base_register) + {$past(i_rel_swnum), 2'b00}) else $error("entry addr");
  nomask_a: assert property (tk && nm |=> o_rel_valid)
    else $error("software number refused");
  refuse_a: assert property (tk && !i_global_irq_enable && !nm |=> o_rel_refused)
    else $error("masked request taken");
  vmon_a: assert property (tk && !i_vmon_maskable && i_rel_swnum[5:1] == 5'h19
    |=> o_rel_refused) else $error("monitor entry taken");
  iic_sel_a: assert property (o_rel_valid && $past(i_rel_swnum) == 6'h0F
    |-> o_rel_is_iic == $past(i_serial_unit_select_bit)) else $error("iic owner");
  c_rst: cover property (o_vec_valid && o_reset_vec);
  c_ref: cover property (o_rel_refused);
  c_iic: cover property (o_rel_valid && o_rel_is_iic);
endmodule // ivr_resolver_sva
bind ivr_resolver ivr_resolver_sva #(.AW(AW)) u_sva (.*);

// ---- ivr_cpu_model.sv ----
// cpu side model: acknowledges requests and supplies vector contents
`timescale 1ns/1ps
module ivr_cpu_model (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_en,
  input wire [3:0] i_dly,
  input wire i_pend,
  input wire i_vec_valid,
  input wire [15:0] i_vec_loc,
  output reg o_ack,
  output wire [15:0] o_data
);
  reg [3:0] cnt_reg;
  reg ph_reg;
  // entry holds loc^5A5A; bus toggles outside a fetch so stale data cannot pass
  assign o_data = i_vec_valid ? i_vec_loc ^ 16'h5A5A : {16{ph_reg}};
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 4'h0;
      o_ack <= 1'b0;
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
      o_ack <= i_en && i_pend && cnt_reg == i_dly && !o_ack;
      cnt_reg <= (i_en && i_pend && !o_ack && cnt_reg != i_dly) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule // ivr_cpu_model

// ---- ivr_resolver_tb_top.sv ----
// self-checking bench for the interrupt vector resolver
`timescale 1ns/1ps
module ivr_resolver_tb_top;
  reg clk = 1'b0, rstn = 1'b0, en = 1'b0, rq = 1'b0, rack = 1'b0, ien = 1'b0, sel = 1'b0;
  reg vm = 1'b0;
  reg [18:0] req = 19'h0;
  reg [5:0] sw = 6'h0;
  reg [3:0] dly = 4'h0;
  wire cack, pend, vv, rvec, rp, rv, iic, rf;
  wire [15:0] cdat, loc;
  wire [5:0] prio;
  wire [19:0] tgt, addr;
  integer failures = 0, num_checks = 0, b;
  localparam [19:0] BASE = 20'h12300;
  always #4 clk = ~clk;
  ivr_resolver u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_watchdog_interval_irq(req[0]),
    .i_voltage_detect_irq(req[1]), .i_pin_edge_irq(req[7:2]), .i_serial2_tx_end_irq(req[8]),
    .i_serial2_clocked_tx_irq(req[9]), .i_serial2_simple_i2c_irq(req[10]),
    .i_serial2_rx_end_irq(req[11]), .i_serial2_rx_error_irq(req[12]),
    .i_timer11_upper_half_irq(req[13]), .i_serial0_tx_end_irq(req[14]),
    .i_serial0_rx_end_irq(req[15]), .i_serial0_rx_error_irq(req[16]),
    .i_timer1_upper_half_irq(req[17]), .i_reset_source(req[18]), .i_cpu_ack(cack),
    .i_vec_entry_data(cdat), .i_rel_req(rq), .i_rel_swnum(sw), .i_global_irq_enable(ien),
    .i_serial_unit_select_bit(sel), .i_vmon_maskable(vm), .i_table_base_register(BASE),
    .i_rel_ack(rack), .o_irq_pending(pend), .o_pend_prio(prio), .o_vec_loc(loc),
    .o_vec_valid(vv), .o_branch_target(tgt), .o_reset_vec(rvec), .o_rel_pending(rp),
    .o_rel_entry_addr(addr), .o_rel_valid(rv), .o_rel_is_iic(iic), .o_rel_refused(rf));
  ivr_cpu_model u_cpu (.i_ref_clk(clk), .i_resetn(rstn), .i_en(en), .i_dly(dly),
    .i_pend(pend), .i_vec_valid(vv), .i_vec_loc(loc), .o_ack(cack), .o_data(cdat));
  // =====
  // checking
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // =====
  // scenarios: bits b..17 raised so the source on bit b must win at priority p; b=18 adds reset source
  task t_vec(input integer b);
    integer p, e, k;
    begin
      p = b < 8 ? b : b < 11 ? 8 : b < 12 ? 9 : b < 14 ? 10 : b < 17 ? b - 3 : 13;
      e = b == 18 ? 0 : p > 10 ? 8 + 2 * p : 4 + 2 * p;
      req = b == 18 ? 19'h7FFFF : {1'b0, 18'h3FFFF << b};
      dly = b[3:0];
      repeat (2) @(negedge clk);
      if (b < 18) chk(prio, p);
      chk(pend, 1);
      en = 1'b1;
      k = 0;
      while (vv !== 1'b1 && k < 40) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k == 40) failures = failures + 1;
      if (k == 40) print_verdict;
      en = 1'b0;
      chk(loc, e);
      chk(rvec, b == 18);
      @(negedge clk);
      chk(tgt, e ^ 16'h5A5A);
      req = 19'h0;
      repeat (3) @(negedge clk);
    end
  endtask
  // back to back: each call holds the request one edge, the next call replaces it
  task t_rel(input [5:0] n, input ie, input v, input s, input ok);
    begin
      sw = n;
      ien = ie;
      vm = v;
      sel = s;
      rq = 1'b1;
      rack = 1'b1;
      @(negedge clk);
      chk({rv, rf}, {ok, !ok});
      chk(rp, ok);
      if (ok) chk(addr, BASE + 4 * n);
      if (n == 6'h0F) chk(iic, s);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(prio, 6'h2C);
    chk(pend, 0);
    for (b = 0; b < 19; b = b + 1) t_vec(b);
    t_rel(6'h16, 1, 1, 0, 1);
    t_rel(6'h18, 1, 1, 0, 1);
    t_rel(6'h19, 1, 1, 0, 1);
    t_rel(6'h1A, 1, 1, 0, 1);
    t_rel(6'h0F, 1, 1, 1, 1);
    t_rel(6'h0F, 1, 1, 0, 1);
    t_rel(6'h20, 0, 1, 0, 1);
    t_rel(6'h29, 0, 1, 0, 1);
    t_rel(6'h1F, 0, 1, 0, 0);
    t_rel(6'h2A, 0, 1, 0, 0);
    t_rel(6'h32, 1, 0, 0, 0);
    t_rel(6'h33, 1, 1, 0, 1);
    t_rel(6'h3F, 1, 1, 0, 1);
    rq = 1'b0;
    rack = 1'b0;
    @(negedge clk);
    print_verdict;
  end
endmodule // ivr_resolver_tb_top
